// ### core/codec_fmt_pkg.sv
package codec_fmt_pkg;

  // Sample coding of a codec
  typedef enum logic [1:0] {
    CODING_LINEAR = 2'b00,
    CODING_ALAW = 2'b10,
    CODING_MULAW = 2'b11
  } coding_t;

  // Decoded settings of one codec
  typedef struct packed {
    coding_t coding;
    logic adc_zc_en;
    logic dac_zc_en;
    logic adc_highpass_filter_bypass;
    logic zc_en;
    logic [3:0] zc_threshold;
  } codec_fmt_t;

  // One register access from the control link decoder
  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

endpackage

// ### core/codec_fmt_regs.svh
`ifndef CODEC_FMT_REGS_SVH
`define CODEC_FMT_REGS_SVH

// Register addresses
`define ADDR_CODEC1_FMT 8'h0F
`define ADDR_CODEC2_FMT 8'h10
`define ADDR_FRAME_SKIP 8'h11
`define ADDR_RSVD_A 8'h12
`define ADDR_RSVD_B 8'h13
`define ADDR_RSVD_C 8'h14
`define ADDR_VERSION 8'h15
// Gain and preamp registers whose updates can be held
`define ADDR_GAIN_0 8'h03
`define ADDR_GAIN_1 8'h04
`define ADDR_GAIN_2 8'h08
`define ADDR_GAIN_3 8'h09
`define ADDR_GAIN_4 8'h0B
`define NUM_GAIN 5

// Format register fields
`define FMT_COMPAND_BIT 7
`define FMT_MULAW_BIT 6
`define FMT_ADC_ZC_OFF_BIT 5
`define FMT_DAC_ZC_OFF_BIT 4
`define FMT_HPF_BYP_BIT 3
`define FMT_ZC_OFF_BIT 2
`define FMT_THR_HI 1
`define FMT_THR_LO 0

// Threshold encodings in LSBs
`define THR_CODE_00 4'h6
`define THR_CODE_01 4'h4
`define THR_CODE_10 4'h8
`define THR_CODE_11 4'hA

// Version register fields
`define VER_ID_HI 7
`define VER_ID_LO 4
`define VER_RSVD_BIT 3
`define VER_HOLD_BIT 2

// Reset values
`define RST_FMT 8'h00
`define RST_SKIP 8'h00
`define RST_RSVD 8'h00
`define RST_GAIN 8'h00
`define RST_VER_RSVD 1'b1
`define RST_HOLD 1'b0
`define RD_ZERO 8'h00

`endif

// ### core/codec_format_control_regs.sv
// Overview of operation
// - Each codec has its own format register
// - Bit 5 one disables ADC zero crossing
// - Bit 4 one disables DAC zero crossing
// - Bit 3 set bypasses ADC highpass filter
// - Bits 1:0 pick threshold 6, 4, 8, 10
// - Second codec has identical layout, own address
// - Count of frames without control information
// - Version nibble binary, never all zero
// - Hold bit set defers gain updates
// - Hold clear applies gain writes immediately
`include "codec_fmt_regs.svh"

module codec_format_control_regs #(
  // Arbitrary silicon version, must not be zero
  parameter logic [3:0] VERSION_ID = 4'h3
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Register write from control link
  input wire codec_fmt_pkg::reg_wr_t i_wr,
  // Register read from control link
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  // Decoded codec settings
  output codec_fmt_pkg::codec_fmt_t o_codec1_fmt,
  output codec_fmt_pkg::codec_fmt_t o_codec2_fmt,
  // Serial link control framing
  output logic [7:0] o_frame_skip_count,
  output logic o_ctrl_every_frame,
  // Applied gain and preamp values
  output logic [`NUM_GAIN*8-1:0] o_gain_active,
  output logic o_update_hold
);
  import codec_fmt_pkg::*;

  logic [7:0] fmt_reg [2];
  logic [7:0] skip_reg;
  logic [7:0] rsvd_reg [3];
  logic ver_rsvd_reg;
  logic hold_reg;
  logic [7:0] shadow_reg [`NUM_GAIN];
  logic [7:0] active_reg [`NUM_GAIN];
  logic [7:0] rd_next;
  logic [7:0] version_byte;

  localparam logic [7:0] GAIN_ADDR [`NUM_GAIN] = '{
    `ADDR_GAIN_0, `ADDR_GAIN_1, `ADDR_GAIN_2, `ADDR_GAIN_3, `ADDR_GAIN_4
  };

  // Address decode of writes
  wire wr_fmt1 = i_wr.wr_en && (i_wr.addr == `ADDR_CODEC1_FMT);
  wire wr_fmt2 = i_wr.wr_en && (i_wr.addr == `ADDR_CODEC2_FMT);
  wire wr_skip = i_wr.wr_en && (i_wr.addr == `ADDR_FRAME_SKIP);
  wire wr_rsa = i_wr.wr_en && (i_wr.addr == `ADDR_RSVD_A);
  wire wr_rsb = i_wr.wr_en && (i_wr.addr == `ADDR_RSVD_B);
  wire wr_rsc = i_wr.wr_en && (i_wr.addr == `ADDR_RSVD_C);
  wire wr_ver = i_wr.wr_en && (i_wr.addr == `ADDR_VERSION);

  // Format, framing and reserved storage
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fmt_reg[0] <= `RST_FMT;
      fmt_reg[1] <= `RST_FMT;
      skip_reg <= `RST_SKIP;
      rsvd_reg[0] <= `RST_RSVD;
      rsvd_reg[1] <= `RST_RSVD;
      rsvd_reg[2] <= `RST_RSVD;
      ver_rsvd_reg <= `RST_VER_RSVD;
      hold_reg <= `RST_HOLD;
    end else begin
      if (wr_fmt1) fmt_reg[0] <= i_wr.data;
      if (wr_fmt2) fmt_reg[1] <= i_wr.data;
      if (wr_skip) skip_reg <= i_wr.data;
      // Stored as written; the host is expected to keep them zero
      if (wr_rsa) rsvd_reg[0] <= i_wr.data;
      if (wr_rsb) rsvd_reg[1] <= i_wr.data;
      if (wr_rsc) rsvd_reg[2] <= i_wr.data;
      if (wr_ver) begin
        ver_rsvd_reg <= i_wr.data[`VER_RSVD_BIT];
        hold_reg <= i_wr.data[`VER_HOLD_BIT];
      end
    end
  end

  // Per codec decode, same layout for both
  function automatic codec_fmt_t decode_fmt(input logic [7:0] r);
    codec_fmt_t f;
    f.coding = !r[`FMT_COMPAND_BIT] ? CODING_LINEAR :
               (r[`FMT_MULAW_BIT] ? CODING_MULAW : CODING_ALAW);
    f.adc_zc_en = !r[`FMT_ADC_ZC_OFF_BIT];
    f.dac_zc_en = !r[`FMT_DAC_ZC_OFF_BIT];
    f.adc_highpass_filter_bypass = r[`FMT_HPF_BYP_BIT];
    f.zc_en = !r[`FMT_ZC_OFF_BIT];
    unique case (r[`FMT_THR_HI:`FMT_THR_LO])
      2'h0: f.zc_threshold = `THR_CODE_00;
      2'h1: f.zc_threshold = `THR_CODE_01;
      2'h2: f.zc_threshold = `THR_CODE_10;
      2'h3: f.zc_threshold = `THR_CODE_11;
    endcase
    return f;
  endfunction

  assign o_codec1_fmt = decode_fmt(fmt_reg[0]);
  assign o_codec2_fmt = decode_fmt(fmt_reg[1]);
  assign o_frame_skip_count = skip_reg;
  assign o_ctrl_every_frame = (skip_reg == `RST_SKIP);
  assign o_update_hold = hold_reg;

  // Version nibble is a fixed strap; zero is rejected below
  assign version_byte = {VERSION_ID, ver_rsvd_reg, hold_reg, 2'h0};

  // Gain shadow and applied copies, one entry per register
  genvar g;
  generate
    for (g = 0; g < `NUM_GAIN; g++) begin : gain_entry
      wire hit = i_wr.wr_en && (i_wr.addr == GAIN_ADDR[g]);
      // Write data bypasses the shadow so an unheld write lands at once
      wire [7:0] active_next = hold_reg ? active_reg[g] :
                               (hit ? i_wr.data : shadow_reg[g]);
      always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          shadow_reg[g] <= `RST_GAIN;
          active_reg[g] <= `RST_GAIN;
        end else begin
          if (hit) shadow_reg[g] <= i_wr.data;
          active_reg[g] <= active_next;
        end
      end
      assign o_gain_active[g*8 +: 8] = active_reg[g];
    end
  endgenerate

  // Read mux; gain addresses return the last written value
  always_comb begin
    rd_next = `RD_ZERO;
    unique case (i_rd_addr)
      `ADDR_CODEC1_FMT: rd_next = fmt_reg[0];
      `ADDR_CODEC2_FMT: rd_next = fmt_reg[1];
      `ADDR_FRAME_SKIP: rd_next = skip_reg;
      `ADDR_RSVD_A: rd_next = rsvd_reg[0];
      `ADDR_RSVD_B: rd_next = rsvd_reg[1];
      `ADDR_RSVD_C: rd_next = rsvd_reg[2];
      `ADDR_VERSION: rd_next = version_byte;
      `ADDR_GAIN_0: rd_next = shadow_reg[0];
      `ADDR_GAIN_1: rd_next = shadow_reg[1];
      `ADDR_GAIN_2: rd_next = shadow_reg[2];
      `ADDR_GAIN_3: rd_next = shadow_reg[3];
      `ADDR_GAIN_4: rd_next = shadow_reg[4];
      default: rd_next = `RD_ZERO;
    endcase
  end

  // Registered read data, one cycle after the address
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) o_rd_data <= `RD_ZERO;
    else o_rd_data <= rd_next;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  // Decoded fields follow the written byte one edge later
  a_codec1_coding: assert property (
    wr_fmt1 |=> (o_codec1_fmt.coding ==
      (!$past(i_wr.data[`FMT_COMPAND_BIT]) ? CODING_LINEAR :
       ($past(i_wr.data[`FMT_MULAW_BIT]) ? CODING_MULAW : CODING_ALAW))))
    else $error("codec1 coding does not match written bits");
  a_codec2_coding: assert property (
    wr_fmt2 |=> (o_codec2_fmt.coding ==
      (!$past(i_wr.data[`FMT_COMPAND_BIT]) ? CODING_LINEAR :
       ($past(i_wr.data[`FMT_MULAW_BIT]) ? CODING_MULAW : CODING_ALAW))))
    else $error("codec2 coding does not match written bits");
  a_adc_zc_gate: assert property (
    wr_fmt2 |=> o_codec2_fmt.adc_zc_en ==
      !$past(i_wr.data[`FMT_ADC_ZC_OFF_BIT]))
    else $error("ADC zero crossing gate wrong");
  a_dac_zc_gate: assert property (
    wr_fmt1 |=> o_codec1_fmt.dac_zc_en !=
      $past(i_wr.data[`FMT_DAC_ZC_OFF_BIT]))
    else $error("DAC zero crossing gate wrong");
  a_hpf_bypass_sel: assert property (
    wr_fmt2 |=> o_codec2_fmt.adc_highpass_filter_bypass ==
      $past(i_wr.data[`FMT_HPF_BYP_BIT]))
    else $error("highpass bypass wrong");
  // Threshold codes 01 and 11 checked against the plain LSB counts
  a_thr_value_map: assert property (
    (fmt_reg[0][`FMT_THR_HI:`FMT_THR_LO] == 2'h1) |->
      (o_codec1_fmt.zc_threshold == 4'h4))
    else $error("threshold code 01 not 4");
  a_thr_top_code: assert property (
    (fmt_reg[1][`FMT_THR_HI:`FMT_THR_LO] == 2'h3) |->
      (o_codec2_fmt.zc_threshold == 4'hA))
    else $error("threshold code 11 not 10");
  a_zc_master_en: assert property (
    wr_fmt1 |=> o_codec1_fmt.zc_en == !$past(i_wr.data[`FMT_ZC_OFF_BIT]))
    else $error("zero crossing master enable wrong");
  // Each codec register touches only its own codec
  a_codec2_isolated: assert property (
    (wr_fmt1 && !wr_fmt2) |=> $stable(o_codec2_fmt))
    else $error("codec2 changed by codec1 write");
  a_codec1_isolated: assert property (
    (wr_fmt2 && !wr_fmt1) |=> $stable(o_codec1_fmt))
    else $error("codec1 changed by codec2 write");
  a_fmt_readback: assert property (
    (i_rd_addr == `ADDR_CODEC1_FMT) |=> (o_rd_data == $past(fmt_reg[0])))
    else $error("codec1 format reads back wrong");
  a_skip_count: assert property (
    wr_skip |=> (o_frame_skip_count == $past(i_wr.data)))
    else $error("frame skip count not stored");
  a_skip_every_frame: assert property (
    wr_skip |=> (o_ctrl_every_frame == ($past(i_wr.data) == 8'h00)))
    else $error("every frame flag wrong after skip write");
  a_version_nonzero: assert property (
    (i_rd_addr == `ADDR_VERSION) |=>
      (o_rd_data[`VER_ID_HI:`VER_ID_LO] != 4'h0))
    else $error("version nibble reads zero");
  a_hold_store: assert property (
    wr_ver |=> (o_update_hold == $past(i_wr.data[`VER_HOLD_BIT])))
    else $error("hold bit not stored");
  a_gain_held: assert property (
    (hold_reg && $past(hold_reg)) |-> $stable(o_gain_active))
    else $error("gain changed while held");
  a_gain_applied: assert property (
    (!hold_reg && i_wr.wr_en && i_wr.addr == `ADDR_GAIN_0)
      |=> o_gain_active[7:0] == $past(i_wr.data))
    else $error("gain write not applied at once");
endmodule

// ### dv/host_model.sv
module host_model (
  // Clock
  input wire logic i_ref_clk,
  // Register access toward the block
  output codec_fmt_pkg::reg_wr_t o_wr,
  output logic [7:0] o_rd_addr,
  input wire logic [7:0] i_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  import codec_fmt_pkg::*;

  // Idle bus from time zero
  initial begin
    o_wr = '0;
    o_rd_addr = 8'h00;
  end

  // One write then an idle cycle, so no edge sees two assignments
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a >= 8'h12 && a <= 8'h14) ? 8'h00 : d;
    @(posedge i_ref_clk) o_wr <= '{1'b1, a, v};
    @(posedge i_ref_clk) o_wr <= '0;
    #1;
  endtask

  // Data is registered, so take it one edge after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk) o_rd_addr <= a;
    @(posedge i_ref_clk) #1;
    d = i_rd_data;
  endtask
endmodule

// ### dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import codec_fmt_pkg::*;

  // Compare, count and report
  `define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin \
    n_errors++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end

  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  reg_wr_t i_wr;
  logic [7:0] i_rd_addr;
  logic [7:0] o_rd_data;
  codec_fmt_t o_codec1_fmt;
  codec_fmt_t o_codec2_fmt;
  logic [7:0] o_frame_skip_count;
  logic o_ctrl_every_frame;
  logic [39:0] o_gain_active;
  logic o_update_hold;
  logic [7:0] rd_val;
  int n_errors = 0;
  int tests_run = 0;

  // 10 MHz clock
  always #50 i_ref_clk = ~i_ref_clk;

  codec_format_control_regs #(.VERSION_ID(4'h5)) dut (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_wr(i_wr),
    .i_rd_addr(i_rd_addr),
    .o_rd_data(o_rd_data),
    .o_codec1_fmt(o_codec1_fmt),
    .o_codec2_fmt(o_codec2_fmt),
    .o_frame_skip_count(o_frame_skip_count),
    .o_ctrl_every_frame(o_ctrl_every_frame),
    .o_gain_active(o_gain_active),
    .o_update_hold(o_update_hold)
  );

  host_model host (
    .i_ref_clk(i_ref_clk),
    .o_wr(i_wr),
    .o_rd_addr(i_rd_addr),
    .i_rd_data(o_rd_data)
  );

  // Expected decode, worked out bit by bit from the field layout
  function automatic codec_fmt_t exp_fmt(logic [7:0] b);
    codec_fmt_t f;
    f.coding = b[7] ? (b[6] ? CODING_MULAW : CODING_ALAW) : CODING_LINEAR;
    f.adc_zc_en = ~b[5];
    f.dac_zc_en = ~b[4];
    f.adc_highpass_filter_bypass = b[3];
    f.zc_en = ~b[2];
    case (b[1:0])
      2'h0: f.zc_threshold = 4'h6;
      2'h1: f.zc_threshold = 4'h4;
      2'h2: f.zc_threshold = 4'h8;
      default: f.zc_threshold = 4'hA;
    endcase
    return f;
  endfunction

  task automatic t_reset;
    #1;
    `CHK(o_codec1_fmt, exp_fmt(8'h00))
    `CHK(o_codec2_fmt, exp_fmt(8'h00))
    `CHK(o_frame_skip_count, 8'h00)
    `CHK(o_ctrl_every_frame, 1'b1)
    `CHK(o_update_hold, 1'b0)
    host.rd(8'h15, rd_val);
    `CHK(rd_val, 8'h58)
    host.rd(8'h12, rd_val);
    `CHK(rd_val, 8'h00)
    host.rd(8'h20, rd_val);
    `CHK(rd_val, 8'h00)
  endtask

  // Every coding and threshold; the two codecs get opposite values
  task automatic t_format;
    logic [7:0] v [8] = '{8'h00, 8'h41, 8'hA2, 8'hD7,
                          8'h3B, 8'hFF, 8'h2C, 8'h95};
    foreach (v[i]) begin
      host.wr(8'h0F, v[i]);
      host.wr(8'h10, ~v[i]);
      `CHK(o_codec1_fmt, exp_fmt(v[i]))
      `CHK(o_codec2_fmt, exp_fmt(~v[i]))
      host.rd(8'h0F, rd_val);
      `CHK(rd_val, v[i])
    end
  endtask

  // Boundary counts, then back to control in every frame
  task automatic t_skip;
    host.wr(8'h11, 8'h01);
    `CHK(o_frame_skip_count, 8'h01)
    `CHK(o_ctrl_every_frame, 1'b0)
    host.wr(8'h11, 8'hFF);
    `CHK(o_frame_skip_count, 8'hFF)
    host.wr(8'h11, 8'h00);
    `CHK(o_ctrl_every_frame, 1'b1)
  endtask

  // Held gain writes stay stored until the hold bit drops
  task automatic t_hold;
    host.wr(8'h03, 8'h55);
    `CHK(o_gain_active[7:0], 8'h55)
    host.wr(8'h15, 8'h0C);
    `CHK(o_update_hold, 1'b1)
    host.rd(8'h15, rd_val);
    `CHK(rd_val, 8'h5C)
    host.wr(8'h04, 8'hAA);
    host.wr(8'h0B, 8'h3C);
    `CHK(o_gain_active[15:8], 8'h00)
    host.rd(8'h04, rd_val);
    `CHK(rd_val, 8'hAA)
    host.wr(8'h15, 8'h08);
    `CHK(o_update_hold, 1'b0)
    @(posedge i_ref_clk) #1;
    `CHK(o_gain_active, {8'h3C, 16'h0000, 8'hAA, 8'h55})
    // The two middle entries, written with the hold clear
    host.wr(8'h08, 8'h81);
    host.wr(8'h09, 8'h7E);
    `CHK(o_gain_active[31:16], 16'h7E81)
  endtask

  task automatic summarize;
    $display("n_errors=%0d tests_run=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence after a 20-cycle reset
  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    t_reset;
    t_format;
    t_skip;
    t_hold;
    summarize;
  end

  // Watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #200000;
    n_errors++;
    summarize;
  end
endmodule
